// >>> logic/ptr_regs.vh
// Register offsets, field positions, reset values and TLP codes for the TLP router
`ifndef PTR_REGS_VH
`define PTR_REGS_VH
// ----------------------------------------
// APB register byte offsets
// ----------------------------------------
`define PTR_OFS_CTRL 8'h00
`define PTR_OFS_ACTFN 8'h04
`define PTR_OFS_MPS 8'h08
`define PTR_OFS_MPS_EFF 8'h0C
`define PTR_OFS_SECBUS 8'h10
`define PTR_OFS_BAR_BASE 8'h14
`define PTR_OFS_BAR_MASK 8'h18
`define PTR_OFS_MSGCMD 8'h1C
`define PTR_OFS_STATUS 8'h20
`define PTR_OFS_ERRSTS 8'h24
`define PTR_OFS_URCNT 8'h28
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PTR_CTRL_ROOT 0
`define PTR_CTRL_ERRMSG 1
`define PTR_CTRL_AER 2
`define PTR_ERR_LOGGED 8
`define PTR_ERR_COR 9
`define PTR_ERR_NONFATAL 10
`define PTR_ERR_FATAL 11
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PTR_RST_CTRL 3'h0
`define PTR_RST_MPS 24'h00_0000
`define PTR_RST_BAR_BASE 32'hFFFF_FFFF
`define PTR_RST_BAR_MASK 32'h0000_0000
// ----------------------------------------
// TLP type field codes
// ----------------------------------------
`define PTR_TYPE_MEM 5'h00
`define PTR_TYPE_IO 5'h02
`define PTR_TYPE_CFG0 5'h04
`define PTR_TYPE_CFG1 5'h05
`define PTR_TYPE_CPL 5'h0A
// ----------------------------------------
// Message codes
// ----------------------------------------
`define PTR_MSG_UNLOCK 8'h00
`define PTR_MSG_PM_NAK 8'h14
`define PTR_MSG_PM_PME 8'h18
`define PTR_MSG_TURNOFF 8'h19
`define PTR_MSG_TO_ACK 8'h1B
`define PTR_MSG_ASSERT_A 8'h20
`define PTR_MSG_DEASSERT_A 8'h24
`define PTR_MSG_ERR_COR 8'h30
`define PTR_MSG_ERR_NONFATAL 8'h31
`define PTR_MSG_ERR_FATAL 8'h33
`define PTR_MSG_ATT_ON 8'h41
`define PTR_MSG_ATT_BLINK 8'h43
`define PTR_MSG_ATT_OFF 8'h40
`define PTR_MSG_PWR_ON 8'h45
`define PTR_MSG_PWR_BLINK 8'h47
`define PTR_MSG_PWR_OFF 8'h44
`define PTR_MSG_HP_LAST 8'h48
`define PTR_MSG_SLOT_PWR 8'h50
`define PTR_MSG_VEND0 8'h7E
`define PTR_MSG_VEND1 8'h7F
// ----------------------------------------
// Completion status
// ----------------------------------------
`define PTR_CPL_SC 3'h0
`define PTR_CPL_UR 3'h1
`endif

// >>> logic/ptr_tlp_router.v
// TLP routing, message generation and multi-function config space
`timescale 1ns/1ps
`include "ptr_regs.vh"

module ptr_tlp_router #(
   parameter NUM_FUNC = 8
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire rx_valid_i,
   input wire [2:0] rx_fmt_i,
   input wire [4:0] rx_type_i,
   input wire [63:0] rx_addr_i,
   input wire [7:0] rx_msg_code_i,
   input wire [2:0] rx_func_i,
   input wire [1:0] rx_cfg_reg_i,
   input wire [7:0] rx_tag_i,
   input wire [31:0] rx_data_i,
   output reg rx_fwd_o,
   output reg rx_int_o,
   output reg rx_ur_o,
   output reg cpl_valid_o,
   output reg [2:0] cpl_status_o,
   output reg [7:0] cpl_tag_o,
   output reg [31:0] cpl_data_o,
   input wire tx_valid_i,
   input wire [2:0] tx_fmt_i,
   input wire [4:0] tx_type_i,
   input wire [7:0] tx_bus_i,
   input wire [1:0] tx_cfg_reg_i,
   input wire [31:0] tx_data_i,
   output reg link_valid_o,
   output reg [2:0] link_fmt_o,
   output reg [4:0] link_type_o,
   output reg [31:0] link_data_o,
   output reg tx_cfg_done_o,
   output reg [31:0] tx_cfg_rdata_o,
   input wire lmi_rd_i,
   input wire lmi_wr_i,
   input wire [1:0] lmi_addr_i,
   input wire [31:0] lmi_din_i,
   output reg lmi_ack_o,
   output reg [31:0] lmi_dout_o,
   input wire turnoff_request_i,
   input wire pme_req_i,
   input wire inta_i,
   input wire msi_req_i,
   input wire [4:0] msi_num_i,
   input wire [4:0] aer_msi_num_i,
   input wire msg_ready_i,
   output reg msg_valid_o,
   output reg [7:0] msg_code_o,
   output reg msi_valid_o,
   output reg [4:0] msi_num_o,
   output reg [3:0] int_status_o,
   output reg serr_o,
   output reg [2:0] mps_eff_o
);

   localparam [3:0] NF = NUM_FUNC[3:0];
   localparam [3:0] NONE = 4'hF;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [4:0] cfg_idx;
      input [2:0] f;
      input [1:0] r;
      begin
         cfg_idx = {f, r};
      end
   endfunction

   function [7:0] msg_code;
      input [3:0] i;
      begin
         case (i)
            4'd0: msg_code = `PTR_MSG_TURNOFF;
            4'd1: msg_code = `PTR_MSG_TO_ACK;
            4'd2: msg_code = `PTR_MSG_ERR_NONFATAL;
            4'd3: msg_code = `PTR_MSG_PM_PME;
            4'd4: msg_code = `PTR_MSG_ASSERT_A;
            4'd5: msg_code = `PTR_MSG_DEASSERT_A;
            4'd6: msg_code = `PTR_MSG_SLOT_PWR;
            4'd7: msg_code = `PTR_MSG_ATT_ON;
            4'd8: msg_code = `PTR_MSG_ATT_BLINK;
            4'd9: msg_code = `PTR_MSG_ATT_OFF;
            4'd10: msg_code = `PTR_MSG_PWR_ON;
            4'd11: msg_code = `PTR_MSG_PWR_BLINK;
            default: msg_code = `PTR_MSG_PWR_OFF;
         endcase
      end
   endfunction

   function [3:0] first_set;
      input [12:0] v;
      integer k;
      begin
         first_set = NONE;
         for (k = 12; k >= 0; k = k - 1) begin
            if (v[k]) first_set = k[3:0];
         end
      end
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [2:0] ctrl_q;
   reg [2:0] actfn_q;
   reg [23:0] mps_q;
   reg [7:0] secbus_q;
   reg [31:0] bar_base_q;
   reg [31:0] bar_mask_q;
   reg [11:0] err_q;
   reg [15:0] urcnt_q;
   reg [12:0] pend_q;
   reg to_seen_q;
   reg inta_q;
   reg turnoff_q;
   reg [31:0] cfg_mem [0:31];
   reg [31:0] rd_mux;
   reg rd_hit;
   reg [2:0] mps_max;
   reg [11:0] err_d;
   reg [12:0] pend_set;
   integer i;
   integer j;

   wire root = ctrl_q[`PTR_CTRL_ROOT];

   // ----------------------------------------
   // APB slave, one wait state
   // ----------------------------------------
   wire apb_acc = psel_i & penable_i;
   wire apb_wr = apb_acc & pready_o & pwrite_i;

   always @* begin
      rd_hit = 1'b1;
      case (paddr_i)
         `PTR_OFS_CTRL: rd_mux = {29'h0, ctrl_q};
         `PTR_OFS_ACTFN: rd_mux = {29'h0, actfn_q};
         `PTR_OFS_MPS: rd_mux = {8'h00, mps_q};
         `PTR_OFS_MPS_EFF: rd_mux = {29'h0, mps_eff_o};
         `PTR_OFS_SECBUS: rd_mux = {24'h00_0000, secbus_q};
         `PTR_OFS_BAR_BASE: rd_mux = bar_base_q;
         `PTR_OFS_BAR_MASK: rd_mux = bar_mask_q;
         `PTR_OFS_MSGCMD: rd_mux = 32'h0000_0000;
         `PTR_OFS_STATUS: rd_mux = {26'h0, serr_o, err_q[`PTR_ERR_LOGGED], int_status_o};
         `PTR_OFS_ERRSTS: rd_mux = {20'h0_0000, err_q};
         `PTR_OFS_URCNT: rd_mux = {16'h0000, urcnt_q};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Receive classification
   // ----------------------------------------
   wire [7:0] mc = rx_msg_code_i;
   wire r_msg = rx_type_i[4:3] == 2'b10;
   wire r_mem = rx_type_i == `PTR_TYPE_MEM;
   wire r_io = rx_type_i == `PTR_TYPE_IO;
   wire r_cpl = rx_type_i == `PTR_TYPE_CPL;
   wire hi_zero = rx_addr_i[63:32] == 32'h0000_0000;
   wire r_m64low = r_mem & rx_fmt_i[0] & hi_zero;
   wire bar_hit = hi_zero & ((rx_addr_i[31:0] & bar_mask_q) == bar_base_q);
   wire r_bar = (r_mem | r_io) & bar_hit & ~r_m64low;
   wire r_vend = r_msg & (mc == `PTR_MSG_VEND0 || mc == `PTR_MSG_VEND1);
   wire m_pm = mc == `PTR_MSG_PM_NAK || mc == `PTR_MSG_PM_PME ||
      mc == `PTR_MSG_TURNOFF || mc == `PTR_MSG_TO_ACK;
   wire m_intx = mc[7:3] == 5'b0_0100;
   wire m_err = mc == `PTR_MSG_ERR_COR || mc == `PTR_MSG_ERR_NONFATAL ||
      mc == `PTR_MSG_ERR_FATAL;
   wire m_hp = mc >= `PTR_MSG_ATT_OFF && mc <= `PTR_MSG_HP_LAST;
   wire m_slot = mc == `PTR_MSG_SLOT_PWR;
   wire m_unlock = mc == `PTR_MSG_UNLOCK;
   // Both consume PM; endpoint also consumes slot power, hot-plug and unlock; root also consumes INTx and errors
   wire r_take = r_msg & (m_pm | (~root & (m_slot | m_hp | m_unlock)) |
      (root & (m_intx | m_err)));
   wire r_cfg_ep = (rx_type_i == `PTR_TYPE_CFG0) & ~root & ({1'b0, rx_func_i} < NF);
   wire r_fwd = r_bar | r_vend | r_cpl;
   wire r_int = r_take | r_cfg_ep;
   wire r_ur = rx_valid_i & ~r_fwd & ~r_int;
   wire r_np = ~(r_msg | (r_mem & rx_fmt_i[1]) | r_cpl);
   wire r_msg_now = rx_valid_i & r_msg;

   // ----------------------------------------
   // Application transmit routing
   // ----------------------------------------
   wire a_cfg0 = tx_type_i == `PTR_TYPE_CFG0;
   wire a_cfg1 = tx_type_i == `PTR_TYPE_CFG1;
   wire a_local = tx_valid_i & root & a_cfg0;
   wire a_link = tx_valid_i & ~a_cfg0 & (~a_cfg1 | root);
   wire a_conv = root & a_cfg1 & (tx_bus_i == secbus_q);

   // ----------------------------------------
   // Config space port arbitration
   // ----------------------------------------
   // Link and app traffic cannot be stalled, so the management port waits instead
   wire rx_cacc = rx_valid_i & r_cfg_ep;
   wire lmi_go = (lmi_rd_i | lmi_wr_i) & ~lmi_ack_o & ~rx_cacc & ~a_local;
   wire [4:0] lmi_idx = cfg_idx(actfn_q, lmi_addr_i);
   wire [4:0] rx_idx = cfg_idx(rx_func_i, rx_cfg_reg_i);
   wire [4:0] ap_idx = cfg_idx(3'h0, tx_cfg_reg_i);

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (i = 0; i < 32; i = i + 1) begin
            cfg_mem[i] <= 32'h0000_0000;
         end
      end else if (rx_cacc & rx_fmt_i[1]) begin
         cfg_mem[rx_idx] <= rx_data_i;
      end else if (a_local & tx_fmt_i[1]) begin
         cfg_mem[ap_idx] <= tx_data_i;
      end else if (lmi_go & lmi_wr_i) begin
         cfg_mem[lmi_idx] <= lmi_din_i;
      end
   end

   // ----------------------------------------
   // Payload size arbitration
   // ----------------------------------------
   always @* begin
      mps_max = 3'h0;
      for (j = 0; j < NUM_FUNC; j = j + 1) begin
         if (mps_q[3*j +: 3] > mps_max) mps_max = mps_q[3*j +: 3];
      end
   end

   // ----------------------------------------
   // Error bits and message requests
   // ----------------------------------------
   wire [3:0] sel = first_set(pend_q);
   wire msg_load = (~msg_valid_o | msg_ready_i) & (sel != NONE);
   wire [12:0] pend_clr = msg_load ? (13'h0001 << sel) : 13'h0000;

   always @* begin
      err_d = err_q;
      if (apb_wr && paddr_i == `PTR_OFS_ERRSTS) err_d = err_q & ~pwdata_i[11:0];
      // Hardware set beats the software clear in the same cycle
      if (r_ur & ({1'b0, rx_func_i} < NF)) begin
         err_d[rx_func_i] = 1'b1;
      end
      if (r_ur & root) err_d[`PTR_ERR_LOGGED] = 1'b1;
      if (r_msg_now & root & m_err) begin
         err_d[`PTR_ERR_LOGGED] = 1'b1;
         if (mc == `PTR_MSG_ERR_COR) err_d[`PTR_ERR_COR] = 1'b1;
         if (mc == `PTR_MSG_ERR_NONFATAL) err_d[`PTR_ERR_NONFATAL] = 1'b1;
         if (mc == `PTR_MSG_ERR_FATAL) err_d[`PTR_ERR_FATAL] = 1'b1;
      end
      pend_set = 13'h0000;
      pend_set[0] = root & turnoff_request_i & ~turnoff_q;
      pend_set[1] = ~root & to_seen_q & turnoff_request_i;
      pend_set[2] = ~root & ctrl_q[`PTR_CTRL_ERRMSG] & r_ur;
      pend_set[3] = ~root & pme_req_i;
      pend_set[4] = ~root & inta_i & ~inta_q;
      pend_set[5] = ~root & ~inta_i & inta_q;
      if (apb_wr && paddr_i == `PTR_OFS_MSGCMD && root) begin
         pend_set[12:6] = pwdata_i[6:0];
      end
   end

   // ----------------------------------------
   // Clocked state and outputs
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         ctrl_q <= `PTR_RST_CTRL;
         actfn_q <= 3'h0;
         mps_q <= `PTR_RST_MPS;
         secbus_q <= 8'h00;
         bar_base_q <= `PTR_RST_BAR_BASE;
         bar_mask_q <= `PTR_RST_BAR_MASK;
         err_q <= 12'h000;
         urcnt_q <= 16'h0000;
         pend_q <= 13'h0000;
         to_seen_q <= 1'b0;
         inta_q <= 1'b0;
         turnoff_q <= 1'b0;
         rx_fwd_o <= 1'b0;
         rx_int_o <= 1'b0;
         rx_ur_o <= 1'b0;
         cpl_valid_o <= 1'b0;
         cpl_status_o <= `PTR_CPL_SC;
         cpl_tag_o <= 8'h00;
         cpl_data_o <= 32'h0000_0000;
         link_valid_o <= 1'b0;
         link_fmt_o <= 3'h0;
         link_type_o <= 5'h00;
         link_data_o <= 32'h0000_0000;
         tx_cfg_done_o <= 1'b0;
         tx_cfg_rdata_o <= 32'h0000_0000;
         lmi_ack_o <= 1'b0;
         lmi_dout_o <= 32'h0000_0000;
         msg_valid_o <= 1'b0;
         msg_code_o <= 8'h00;
         msi_valid_o <= 1'b0;
         msi_num_o <= 5'h00;
         int_status_o <= 4'h0;
         serr_o <= 1'b0;
         mps_eff_o <= 3'h0;
      end else begin
         pready_o <= apb_acc & ~pready_o;
         pslverr_o <= apb_acc & ~pready_o & ~rd_hit;
         if (apb_acc & ~pready_o) prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
         if (apb_wr) begin
            case (paddr_i)
               `PTR_OFS_CTRL: ctrl_q <= pwdata_i[2:0];
               `PTR_OFS_ACTFN: actfn_q <= pwdata_i[2:0];
               `PTR_OFS_MPS: mps_q <= pwdata_i[23:0];
               `PTR_OFS_SECBUS: secbus_q <= pwdata_i[7:0];
               `PTR_OFS_BAR_BASE: bar_base_q <= pwdata_i;
               `PTR_OFS_BAR_MASK: bar_mask_q <= pwdata_i;
               default: ;
            endcase
         end
         err_q <= err_d;
         serr_o <= root & err_d[`PTR_ERR_LOGGED];
         mps_eff_o <= mps_max;
         if (r_ur && urcnt_q != 16'hFFFF) urcnt_q <= urcnt_q + 16'h0001;
         rx_fwd_o <= rx_valid_i & r_fwd;
         rx_int_o <= rx_valid_i & r_int;
         rx_ur_o <= r_ur;
         if (r_msg_now & root & m_intx) begin
            int_status_o[mc[1:0]] <= ~mc[2];
         end
         if (~root & pend_set[1]) to_seen_q <= 1'b0;
         if (r_msg_now & ~root & mc == `PTR_MSG_TURNOFF) to_seen_q <= 1'b1;
         turnoff_q <= turnoff_request_i;
         inta_q <= inta_i;
         pend_q <= (pend_q & ~pend_clr) | pend_set;
         if (msg_load) begin
            msg_valid_o <= 1'b1;
            msg_code_o <= msg_code(sel);
         end else if (msg_ready_i) begin
            msg_valid_o <= 1'b0;
         end
         // Completions for endpoint config requests and non-posted URs
         cpl_valid_o <= rx_cacc | (r_ur & r_np);
         cpl_status_o <= rx_cacc ? `PTR_CPL_SC : `PTR_CPL_UR;
         cpl_tag_o <= rx_tag_i;
         cpl_data_o <= (rx_cacc & ~rx_fmt_i[1]) ? cfg_mem[rx_idx] : 32'h0000_0000;
         link_valid_o <= a_link;
         link_fmt_o <= tx_fmt_i;
         link_type_o <= a_conv ? `PTR_TYPE_CFG0 : tx_type_i;
         link_data_o <= tx_data_i;
         tx_cfg_done_o <= a_local;
         tx_cfg_rdata_o <= a_local ? cfg_mem[ap_idx] : tx_cfg_rdata_o;
         lmi_ack_o <= lmi_go;
         if (lmi_go) lmi_dout_o <= cfg_mem[lmi_idx];
         // Root error MSI uses the application's chosen vector
         if (root & ctrl_q[`PTR_CTRL_AER] & err_d[`PTR_ERR_LOGGED] &
               ~err_q[`PTR_ERR_LOGGED]) begin
            msi_valid_o <= 1'b1;
            msi_num_o <= aer_msi_num_i;
         end else begin
            msi_valid_o <= ~root & msi_req_i;
            msi_num_o <= msi_num_i;
         end
      end
   end

endmodule // ptr_tlp_router

// >>> verif/ptr_msg_sink.sv
// Message sink standing for the link side of generated messages
`timescale 1ns/1ps
module ptr_msg_sink (
   input wire clk_i,
   input wire rst_n_i,
   input wire msg_valid_o,
   input wire [7:0] msg_code_o,
   input wire stall_i,
   output logic msg_ready_i,
   output logic [7:0] got_code_o,
   output int got_n_o
);
   // Stall comes only from the bench, to test message holding
   always @(posedge clk_i) begin
      msg_ready_i <= rst_n_i && !stall_i;
      if (!rst_n_i) begin
         got_n_o <= 0;
         got_code_o <= 8'h00;
      end else if (msg_valid_o && msg_ready_i) begin
         got_n_o <= got_n_o + 1;
         got_code_o <= msg_code_o;
      end
   end
endmodule // ptr_msg_sink

// >>> verif/ptr_tlp_router_bench.sv
// Self-checking bench for the TLP router
`timescale 1ns/1ps
`include "ptr_regs.vh"
module ptr_tlp_router_bench;
   // Message type with routing towards the root
   localparam logic [4:0] MSG = 5'h10;
   logic clk_i = 0, rst_n_i = 0, stall_i = 0, err_s, cv;
   logic psel_i = 0, penable_i = 0, pwrite_i = 0, rx_valid_i = 0, tx_valid_i = 0;
   logic lmi_rd_i = 0, lmi_wr_i = 0, turnoff_request_i = 0;
   logic [7:0] paddr_i = 0, rx_msg_code_i = 0, rx_tag_i = 0, tx_bus_i = 0;
   logic [31:0] pwdata_i = 0, rx_data_i = 0, tx_data_i = 0, lmi_din_i = 0, r, dw, cd;
   logic [2:0] rx_fmt_i = 0, rx_func_i = 0, tx_fmt_i = 0, cs;
   logic [4:0] rx_type_i = 0, tx_type_i = 0, lt;
   logic [1:0] rx_cfg_reg_i = 0, tx_cfg_reg_i = 0, lmi_addr_i = 0;
   logic [63:0] rx_addr_i = 0;
   wire pme_req_i = 1'b0, inta_i = 1'b0, msi_req_i = 1'b0;
   wire [4:0] msi_num_i = 5'h00;
   logic [4:0] aer_msi_num_i = 5'h0B;
   logic [5:0] mv;
   wire pready_o, pslverr_o, rx_fwd_o, rx_int_o, rx_ur_o, cpl_valid_o, link_valid_o;
   wire tx_cfg_done_o, lmi_ack_o, msg_ready_i, msg_valid_o, msi_valid_o, serr_o;
   wire [31:0] prdata_o, cpl_data_o, link_data_o, tx_cfg_rdata_o, lmi_dout_o;
   wire [2:0] cpl_status_o, link_fmt_o, mps_eff_o;
   wire [7:0] cpl_tag_o, msg_code_o, got_code_o;
   wire [4:0] link_type_o, msi_num_o;
   wire [3:0] int_status_o;
   int got_n_o, errors = 0, tests_run = 0, cyc = 0, i;
   logic [7:0] mc [5] = '{`PTR_MSG_VEND0, `PTR_MSG_VEND1, `PTR_MSG_PM_PME,
      `PTR_MSG_SLOT_PWR, `PTR_MSG_ATT_ON};
   logic [2:0] ex [5] = '{3'b100, 3'b100, 3'b010, 3'b010, 3'b010};
   logic [7:0] ord [7] = '{`PTR_MSG_SLOT_PWR, `PTR_MSG_ATT_ON, `PTR_MSG_ATT_BLINK,
      `PTR_MSG_ATT_OFF, `PTR_MSG_PWR_ON, `PTR_MSG_PWR_BLINK, `PTR_MSG_PWR_OFF};
   ptr_tlp_router DUT (.*);
   ptr_msg_sink SINK (.*);
   always #12.5 clk_i = ~clk_i;
   // ----------------------------------------
   // Shared drivers and compare
   // ----------------------------------------
   task chk(input logic [63:0] a, input logic [63:0] e);
      tests_run++;
      if (a !== e) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, a, e);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         print_verdict;
      end
   end
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 20);
      r = prdata_o;
      err_s = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task mgmt(input logic w, input logic [1:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      lmi_rd_i <= !w;
      lmi_wr_i <= w;
      lmi_addr_i <= a;
      lmi_din_i <= d;
      n = 0;
      do @(posedge clk_i); while (lmi_ack_o !== 1'b1 && ++n < 20);
      r = lmi_dout_o;
      lmi_rd_i <= 1'b0;
      lmi_wr_i <= 1'b0;
   endtask
   // Function, config word and tag ride in the address argument
   task rx(input logic [2:0] f, input logic [4:0] t, input logic [63:0] ad,
         input logic [7:0] m, input logic [2:0] e);
      @(posedge clk_i);
      rx_valid_i <= 1'b1;
      rx_fmt_i <= f;
      rx_type_i <= t;
      rx_addr_i <= ad;
      rx_msg_code_i <= m;
      rx_func_i <= ad[10:8];
      rx_cfg_reg_i <= ad[3:2];
      rx_tag_i <= ad[7:0];
      rx_data_i <= dw;
      @(posedge clk_i);
      rx_valid_i <= 1'b0;
      @(posedge clk_i);
      cv = cpl_valid_o;
      cs = cpl_status_o;
      cd = cpl_data_o;
      mv = {msi_valid_o, msi_num_o};
      chk({rx_fwd_o, rx_int_o, rx_ur_o}, e);
   endtask
   task tx(input logic [4:0] t, input logic [7:0] b, input logic [1:0] e);
      @(posedge clk_i);
      tx_valid_i <= 1'b1;
      tx_type_i <= t;
      tx_bus_i <= b;
      tx_data_i <= dw;
      @(posedge clk_i);
      tx_valid_i <= 1'b0;
      @(posedge clk_i);
      lt = link_type_o;
      chk({link_valid_o, tx_cfg_done_o}, e);
   endtask
   task msg(input logic [7:0] e);
      int n, k;
      k = got_n_o;
      n = 0;
      do @(posedge clk_i); while (got_n_o == k && ++n < 60);
      chk(got_code_o, e);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_ep;
      dw = 32'hA5A5_0001;
      rx(3'h2, `PTR_TYPE_CFG0, 64'h0304, 8'h00, 3'b010);
      rx(3'h0, `PTR_TYPE_CFG0, 64'h0304, 8'h00, 3'b010);
      chk({cv, cs, cd}, {1'b1, `PTR_CPL_SC, dw});
      chk(cpl_tag_o, 8'h04);
      rx(3'h0, `PTR_TYPE_CFG0, 64'h0204, 8'h00, 3'b010);
      chk(cd, 32'h0000_0000);
      apb(1'b1, `PTR_OFS_ACTFN, 32'h0000_0003);
      mgmt(1'b0, 2'h1, 32'h0000_0000);
      chk(r, dw);
      mgmt(1'b1, 2'h2, 32'h0000_0077);
      rx(3'h0, `PTR_TYPE_CFG0, 64'h0308, 8'h00, 3'b010);
      chk(cd, 32'h0000_0077);
      rx(3'h0, `PTR_TYPE_MEM, 64'h1000, 8'h00, 3'b001);
      chk({cv, cs}, {1'b1, `PTR_CPL_UR});
      turnoff_request_i <= 1'b1;
      rx(3'h0, MSG, '0, `PTR_MSG_TURNOFF, 3'b010);
      msg(`PTR_MSG_TO_ACK);
      turnoff_request_i <= 1'b0;
      for (i = 0; i < 5; i++) rx(3'h2, MSG, '0, mc[i], ex[i]);
      apb(1'b1, `PTR_OFS_MPS, 32'h0002_0001);
      repeat (2) @(posedge clk_i);
      chk(mps_eff_o, 3'h4);
      apb(1'b0, `PTR_OFS_MPS_EFF, 32'h0000_0000);
      chk(r, 32'h0000_0004);
      apb(1'b1, `PTR_OFS_MPS, 32'h006D_B6DB);
      repeat (2) @(posedge clk_i);
      chk(mps_eff_o, 3'h3);
      $display("endpoint test done");
   endtask
   task t_bar;
      apb(1'b0, 8'h2C, 32'h0000_0000);
      chk({err_s, r}, 33'h1_0000_0000);
      apb(1'b1, `PTR_OFS_BAR_BASE, 32'h1000_0000);
      apb(1'b1, `PTR_OFS_BAR_MASK, 32'hF000_0000);
      rx(3'h0, `PTR_TYPE_MEM, 64'h1000_0040, 8'h00, 3'b100);
      chk(cv, 1'b0);
      rx(3'h2, `PTR_TYPE_IO, 64'h1000_0008, 8'h00, 3'b100);
      rx(3'h2, `PTR_TYPE_MEM, 64'h2000_0000, 8'h00, 3'b001);
      chk(cv, 1'b0);
      rx(3'h1, `PTR_TYPE_MEM, 64'h1000_0040, 8'h00, 3'b001);
      $display("address window test done");
   endtask
   task t_root;
      apb(1'b1, `PTR_OFS_SECBUS, 32'h0000_0007);
      apb(1'b1, `PTR_OFS_CTRL, 32'h0000_0005);
      for (i = 0; i < 4; i++) begin
         rx(3'h0, MSG, '0, `PTR_MSG_ASSERT_A + 8'(i), 3'b010);
         @(posedge clk_i);
         chk(int_status_o, 4'h1 << i);
         rx(3'h0, MSG, '0, `PTR_MSG_DEASSERT_A + 8'(i), 3'b010);
         @(posedge clk_i);
         chk(int_status_o, 4'h0);
      end
      tx(`PTR_TYPE_CFG1, 8'h07, 2'b10);
      chk(lt, `PTR_TYPE_CFG0);
      tx(`PTR_TYPE_CFG1, 8'h08, 2'b10);
      chk(lt, `PTR_TYPE_CFG1);
      tx(`PTR_TYPE_CFG0, 8'h07, 2'b01);
      tx(`PTR_TYPE_MEM, 8'h00, 2'b10);
      chk(link_data_o, dw);
      tx(`PTR_TYPE_CPL, 8'h00, 2'b10);
      rx(3'h0, `PTR_TYPE_MEM, 64'h3000_0000, 8'h00, 3'b001);
      chk(mv, {1'b1, 5'h0B});
      repeat (3) @(posedge clk_i);
      chk(serr_o, 1'b1);
      apb(1'b1, `PTR_OFS_ERRSTS, 32'h0000_0100);
      repeat (3) @(posedge clk_i);
      chk(serr_o, 1'b0);
      rx(3'h0, MSG, '0, `PTR_MSG_ERR_FATAL, 3'b010);
      stall_i <= 1'b1;
      turnoff_request_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      stall_i <= 1'b0;
      msg(`PTR_MSG_TURNOFF);
      turnoff_request_i <= 1'b0;
      apb(1'b1, `PTR_OFS_MSGCMD, 32'h0000_007F);
      for (i = 0; i < 7; i++) msg(ord[i]);
      $display("root test done");
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_ep;
      t_bar;
      t_root;
      print_verdict;
   end
endmodule // ptr_tlp_router_bench
bind ptr_tlp_router ptr_tlp_router_sva #(.NUM_FUNC(NUM_FUNC)) u_sva (.*);

// >>> verif/ptr_tlp_router_sva.sv
// Port-level assertions for the TLP router
`timescale 1ns/1ps
module ptr_tlp_router_sva #(
   parameter NUM_FUNC = 8
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire rx_valid_i,
   input wire rx_fwd_o,
   input wire rx_int_o,
   input wire rx_ur_o,
   input wire cpl_valid_o,
   input wire [2:0] cpl_status_o,
   input wire tx_valid_i,
   input wire link_valid_o,
   input wire tx_cfg_done_o,
   input wire [3:0] int_status_o,
   input wire msg_valid_o,
   input wire msg_ready_i,
   input wire [7:0] msg_code_o,
   input wire lmi_rd_i,
   input wire lmi_wr_i,
   input wire lmi_ack_o
);
   // ----------------------------------------
   // Sequences and checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence one_class;
      $onehot({rx_fwd_o, rx_int_o, rx_ur_o});
   endsequence
   sequence no_class;
      !(rx_fwd_o || rx_int_o || rx_ur_o);
   endsequence
   sequence msg_held;
      msg_valid_o && $stable(msg_code_o);
   endsequence
   rx_class_a: assert property (rx_valid_i |=> one_class)
      else $error("header not classified exactly once");
   rx_idle_a: assert property (!rx_valid_i |=> no_class)
      else $error("classification without a header");
   cpl_cause_a: assert property (cpl_valid_o |-> $past(rx_valid_i))
      else $error("completion without a received header");
   cpl_kind_a: assert property (cpl_valid_o |-> cpl_status_o == {2'b00, rx_ur_o} && !rx_fwd_o)
      else $error("completion status does not match class");
   link_cause_a: assert property (link_valid_o |-> $past(tx_valid_i))
      else $error("link output without a transmit request");
   cfg_local_a: assert property (tx_cfg_done_o |-> !link_valid_o && $past(tx_valid_i))
      else $error("local config result also sent to link");
   intx_cause_a: assert property (!$stable(int_status_o) |-> $past(rx_valid_i))
      else $error("interrupt status moved without a message");
   msg_hold_a: assert property (msg_valid_o && !msg_ready_i |=> msg_held)
      else $error("message dropped or changed while stalled");
   mgmt_ack_a: assert property (lmi_ack_o |-> ($past(lmi_rd_i) || $past(lmi_wr_i)) ##1 !lmi_ack_o)
      else $error("management acknowledge without request");
   stall_c: cover property (msg_valid_o && !msg_ready_i);
endmodule // ptr_tlp_router_sva
